/* File: rtl/pmbus_cmd_defs.svh */
// Constants for the converter command set: command codes, field layouts,
// setting ranges, reset values and timing counts.
// Assumes inclusion by bare name from every file that needs a constant.
`ifndef PMBUS_CMD_DEFS_SVH
`define PMBUS_CMD_DEFS_SVH

// Command codes.
`define CMD_OPERATION     8'h01
`define CMD_ONOFF_CFG     8'h02
`define CMD_STORE_ALL     8'h11
`define CMD_VOUT_MODE     8'h20
`define CMD_VOUT_SET      8'h21
`define CMD_MARGIN_HI     8'h25
`define CMD_MARGIN_LO     8'h26
`define CMD_VIN_ON        8'h35
`define CMD_VIN_OFF       8'h36
`define CMD_TON_DELAY     8'h60
`define CMD_TON_RISE      8'h61
`define CMD_READ_VIN      8'h88
`define CMD_READ_VOUT     8'h8B
`define CMD_WP_CTRL       8'hD0
`define CMD_VOUT_OFS_CAL  8'hD4
`define CMD_VIN_OFS_CAL   8'hD5
`define CMD_VIN_GAIN_CAL  8'hD6

// Field positions and fixed exponents.
`define OP_ON_BIT         7
`define OP_MARGIN_MSB     5
`define OP_MARGIN_LSB     2
`define CFG_CMD_BIT       3
`define MARGIN_LOW        4'h6
`define MARGIN_HIGH       4'hA
`define VOUT_MODE_VAL     8'h14
`define EXP_M3            5'h1D
`define EXP_M1            5'h1F
`define GAIN_SHIFT        13

// Ranges in mantissa counts.
`define VIN_MANT_MIN      11'h100
`define VIN_MANT_MAX      11'h170
`define DLY_MANT_MIN      11'h014
`define RISE_MANT_MIN     11'h01E
`define TON_MANT_MAX      11'h3E8
`define VOUT_MANT_MIN     16'h9800
`define VOUT_MANT_MAX     16'hC000

// Reset values.
`define OP_RST            8'h00
`define CFG_RST           5'h1F
`define WP_RST            1'b1
`define VIN_ON_RST        16'hE920
`define VIN_OFF_RST       16'hE910
`define TON_DELAY_RST     16'hF814
`define TON_RISE_RST      16'hF81E
`define VOUT_SET_RST      16'hC000
`define MARGIN_HI_RST     16'hC000
`define MARGIN_LO_RST     16'h9800

// Timing: resolution step of the start-up timers.
`define CLK_PERIOD_NS     100
`define TON_STEP_NS       500000
`define TON_STEP_CYC      (`TON_STEP_NS / `CLK_PERIOD_NS)

`endif

/* File: rtl/pmbus_cmd_pkg.sv */
// Types for the converter command set: power state and the two state
// records, one per clock domain.
// Assumes the constants header is included where values are needed.
package pmbus_cmd_pkg;

   typedef enum logic [3:0] {
      PWR_OFF   = 4'h1,
      PWR_DELAY = 4'h2,
      PWR_RISE  = 4'h4,
      PWR_ON    = 4'h8
   } pwr_state_type;

   typedef struct packed {
      logic          req1;
      logic          req2;
      logic          req3;
      logic          pin1;
      logic          pin2;
      logic [15:0]   vin1;
      logic [15:0]   vin2;
      logic [15:0]   vout1;
      logic [15:0]   vout2;
      logic [7:0]    op;
      logic          cfg_cmd;
      logic          wp;
      logic [15:0]   vin_on;
      logic [15:0]   vin_off;
      logic [15:0]   ton_delay;
      logic [15:0]   ton_rise;
      logic [15:0]   vout_set;
      logic [15:0]   margin_hi;
      logic [15:0]   margin_lo;
      logic          ack;
      logic [15:0]   rd_word;
      logic          store;
      logic          refused;
      pwr_state_type pst;
      logic [15:0]   tick;
      logic [10:0]   cnt;
      logic          uv_ok;
      logic          pwr_en;
      logic          soft_start;
      logic [15:0]   vout_target;
      logic [15:0]   read_vout;
      logic [15:0]   read_vin;
   } core_state_type;

   typedef struct packed {
      logic [1:0]    wr_cnt;
      logic [7:0]    cmd;
      logic [15:0]   data;
      logic [7:0]    req_cmd;
      logic [15:0]   req_data;
      logic [1:0]    req_n;
      logic          req_tgl;
      logic          ack1;
      logic          ack2;
      logic          ack3;
      logic [15:0]   rd_word;
      logic          rd_hi;
      logic [7:0]    rd_byte;
      logic          busy;
   } link_state_type;

endpackage : pmbus_cmd_pkg

/* File: rtl/pmbus_power_command_set.sv */
// Command and setting logic of an isolated bus converter: settings, write
// protection, store to non-volatile memory, on/off, start-up timing,
// margining and corrected readback.
// Assumes a byte-level link on link_clk in front of it and converter
// samples arriving unsynchronised from the analog side.
//
// Functional notes
// - Output voltage words: unsigned mantissa, exponent -12.
// - Other words: 11-bit mantissa, 5-bit exponent.
// - Low byte travels before high byte.
// - Write protection active after reset, command toggles.
// - Store-all copies settings to non-volatile memory.
// - Operation bit 7 enables or disables output.
// - Config uses five bits; bit 3 writable.
// - Power-up waits for pin and command.
// - Command bit selects obeying operation enable.
// - Pin bit demands asserted on/off pin.
// - Input thresholds 32 V to 46 V, 0.125 V.
// - Input thresholds exponent -3, mantissa positive.
// - Delay 10-500 ms, rise 15-500 ms.
// - Timing words exponent -1, mantissa positive.
// - Set-point 9.5 V to 12 V; mode query.
// - Operation bits 5:2 select margin state.
// - Output readback: unsigned mantissa, exponent -12.
// - Output offset calibration signed, applied to readback.
// - Input readback exponent -3, positive mantissa.
// - Input offset calibration exponent -3, readable.
// - Input gain calibration unsigned, readable.
`timescale 1ns/1ps
`include "pmbus_cmd_defs.svh"

module pmbus_power_command_set #(
   parameter int          TON_STEP_CYCLES = `TON_STEP_CYC,
   parameter logic [15:0] VOUT_OFS_CAL    = 16'h0000,
   parameter logic [15:0] VIN_OFS_CAL     = 16'hE800,
   parameter logic [15:0] VIN_GAIN_CAL    = 16'h2000
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        link_clk,
   input  wire logic        link_wr_valid,
   input  wire logic [7:0]  link_wr_byte,
   input  wire logic        link_wr_last,
   input  wire logic        link_rd_valid,
   output logic      [7:0]  link_rd_byte,
   output logic             link_busy,
   input  wire logic        onoff_pin,
   input  wire logic [15:0] adc_vin,
   input  wire logic [15:0] adc_vout,
   output logic             pwr_enable,
   output logic             soft_start,
   output logic      [15:0] vout_target,
   output logic             wp_active,
   output logic             cmd_refused
);

   pmbus_cmd_pkg::core_state_type c_q;
   pmbus_cmd_pkg::core_state_type c_d;
   pmbus_cmd_pkg::link_state_type l_q;
   pmbus_cmd_pkg::link_state_type l_d;
   logic [15:0] nvm [0:7];
   logic        exec;
   logic        want;
   logic [31:0] gain_prod;
   logic [15:0] vin_corr;

   // Checks a two-byte linear word against a fixed exponent and range.
   function automatic logic lin_ok(input logic [15:0] w,
                                   input logic [4:0]  e,
                                   input logic [10:0] lo,
                                   input logic [10:0] hi);
      lin_ok = (w[15:11] == e) && (w[10:0] >= lo) && (w[10:0] <= hi);
   endfunction : lin_ok

   ////////////////////////////////////////////////////////////////////////
   // Link domain: bytes are assembled into a request and handed to the
   // core by a toggle; the reply word comes back under the ack toggle.
   always_comb begin
      l_d      = l_q;
      l_d.ack1 = c_q.ack;
      l_d.ack2 = l_q.ack1;
      l_d.ack3 = l_q.ack2;
      if (l_q.ack3 != l_q.ack2) begin
         l_d.rd_word = c_q.rd_word;
         l_d.rd_hi   = 1'b0;
      end
      if (link_wr_valid) begin
         l_d.rd_hi = 1'b0;
         unique case (l_q.wr_cnt)
            2'h0:    l_d.cmd = link_wr_byte;
            2'h1:    l_d.data[7:0] = link_wr_byte;
            default: l_d.data[15:8] = link_wr_byte;
         endcase
         l_d.wr_cnt = (l_q.wr_cnt == 2'h2) ? 2'h2 : l_q.wr_cnt + 2'h1;
         if (link_wr_last) begin
            l_d.wr_cnt   = 2'h0;
            l_d.req_cmd  = (l_q.wr_cnt == 2'h0) ? link_wr_byte : l_q.cmd;
            l_d.req_data = l_q.data;
            l_d.req_n    = l_q.wr_cnt;
            if (l_q.wr_cnt == 2'h1) begin
               l_d.req_data[7:0] = link_wr_byte;
            end
            if (l_q.wr_cnt == 2'h2) begin
               l_d.req_data[15:8] = link_wr_byte;
            end
            l_d.req_tgl = ~l_q.req_tgl;
         end
      end
      // Low byte first, then high, then low again for a repeat read.
      if (link_rd_valid) begin
         l_d.rd_byte = l_q.rd_hi ? l_q.rd_word[15:8] : l_q.rd_word[7:0];
         l_d.rd_hi   = ~l_q.rd_hi;
      end
      l_d.busy = (l_d.req_tgl != l_q.ack2) || (l_q.ack2 != l_q.ack3);
   end

   // Link registers; they move only while the host clocks a frame.
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core helpers: a new request is seen once its toggle has settled.
   assign exec      = c_q.req3 != c_q.req2;
   assign gain_prod = {16'h0000, c_q.vin2} * {16'h0000, VIN_GAIN_CAL};
   assign vin_corr  = 16'(gain_prod >> `GAIN_SHIFT) + 16'(signed'(VIN_OFS_CAL[10:0]));
   // Bits 4, 2 and 1 are fixed at one, so pin and polarity always count.
   assign want = c_q.uv_ok
              && (!c_q.cfg_cmd || c_q.op[`OP_ON_BIT])
              && c_q.pin2;

   ////////////////////////////////////////////////////////////////////////
   // Core next state: command execution, start-up sequencing, readback.
   always_comb begin
      c_d         = c_q;
      c_d.req1    = l_q.req_tgl;
      c_d.req2    = c_q.req1;
      c_d.req3    = c_q.req2;
      c_d.pin1    = onoff_pin;
      c_d.pin2    = c_q.pin1;
      c_d.vin1    = adc_vin;
      c_d.vin2    = c_q.vin1;
      c_d.vout1   = adc_vout;
      c_d.vout2   = c_q.vout1;
      c_d.store   = 1'b0;
      c_d.refused = 1'b0;
      if (exec) begin
         c_d.ack = ~c_q.ack;
         if (l_q.req_n == 2'h0) begin
            // A bare code selects a read, or commits the settings.
            c_d.store = (l_q.req_cmd == `CMD_STORE_ALL);
            unique case (l_q.req_cmd)
               `CMD_OPERATION:    c_d.rd_word = {8'h00, c_q.op};
               `CMD_ONOFF_CFG:    c_d.rd_word = {11'h000, 1'b1, c_q.cfg_cmd,
                                                 3'h7};
               `CMD_WP_CTRL:      c_d.rd_word = {15'h0000, c_q.wp};
               `CMD_VOUT_MODE:    c_d.rd_word = {8'h00, `VOUT_MODE_VAL};
               `CMD_VOUT_SET:     c_d.rd_word = c_q.vout_set;
               `CMD_MARGIN_HI:    c_d.rd_word = c_q.margin_hi;
               `CMD_MARGIN_LO:    c_d.rd_word = c_q.margin_lo;
               `CMD_VIN_ON:       c_d.rd_word = c_q.vin_on;
               `CMD_VIN_OFF:      c_d.rd_word = c_q.vin_off;
               `CMD_TON_DELAY:    c_d.rd_word = c_q.ton_delay;
               `CMD_TON_RISE:     c_d.rd_word = c_q.ton_rise;
               `CMD_READ_VOUT:    c_d.rd_word = c_q.read_vout;
               `CMD_READ_VIN:     c_d.rd_word = c_q.read_vin;
               `CMD_VOUT_OFS_CAL: c_d.rd_word = VOUT_OFS_CAL;
               `CMD_VIN_OFS_CAL:  c_d.rd_word = VIN_OFS_CAL;
               `CMD_VIN_GAIN_CAL: c_d.rd_word = VIN_GAIN_CAL;
               default: begin
                  c_d.rd_word = 16'h0000;
                  c_d.refused = (l_q.req_cmd != `CMD_STORE_ALL);
               end
            endcase
         end else if (l_q.req_n == 2'h1) begin
            c_d.refused = 1'b1;
            if (l_q.req_cmd == `CMD_WP_CTRL) begin
               c_d.wp      = l_q.req_data[0];
               c_d.refused = 1'b0;
            end else if (l_q.req_cmd == `CMD_OPERATION) begin
               c_d.op      = l_q.req_data[7:0];
               c_d.refused = 1'b0;
            end else if (l_q.req_cmd == `CMD_ONOFF_CFG && !c_q.wp) begin
               c_d.cfg_cmd = l_q.req_data[`CFG_CMD_BIT];
               c_d.refused = 1'b0;
            end
         end else begin
            // Word writes: refused under protection or out of range.
            c_d.refused = 1'b1;
            if (!c_q.wp) begin
               unique case (l_q.req_cmd)
                  `CMD_VIN_ON, `CMD_VIN_OFF: begin
                     if (lin_ok(l_q.req_data, `EXP_M3, `VIN_MANT_MIN,
                                `VIN_MANT_MAX)) begin
                        c_d.refused = 1'b0;
                        if (l_q.req_cmd == `CMD_VIN_ON) begin
                           c_d.vin_on = l_q.req_data;
                        end else begin
                           c_d.vin_off = l_q.req_data;
                        end
                     end
                  end
                  `CMD_TON_DELAY: begin
                     if (lin_ok(l_q.req_data, `EXP_M1, `DLY_MANT_MIN,
                                `TON_MANT_MAX)) begin
                        c_d.ton_delay = l_q.req_data;
                        c_d.refused   = 1'b0;
                     end
                  end
                  `CMD_TON_RISE: begin
                     if (lin_ok(l_q.req_data, `EXP_M1, `RISE_MANT_MIN,
                                `TON_MANT_MAX)) begin
                        c_d.ton_rise = l_q.req_data;
                        c_d.refused  = 1'b0;
                     end
                  end
                  `CMD_VOUT_SET, `CMD_MARGIN_HI, `CMD_MARGIN_LO: begin
                     if (l_q.req_data >= `VOUT_MANT_MIN &&
                         l_q.req_data <= `VOUT_MANT_MAX) begin
                        c_d.refused = 1'b0;
                        if (l_q.req_cmd == `CMD_VOUT_SET) begin
                           c_d.vout_set = l_q.req_data;
                        end else if (l_q.req_cmd == `CMD_MARGIN_HI) begin
                           c_d.margin_hi = l_q.req_data;
                        end else begin
                           c_d.margin_lo = l_q.req_data;
                        end
                     end
                  end
                  default: c_d.refused = 1'b1;
               endcase
            end
         end
      end

      // Input undervoltage lockout with the programmed hysteresis.
      if (vin_corr[10:0] >= c_q.vin_on[10:0]) begin
         c_d.uv_ok = 1'b1;
      end else if (vin_corr[10:0] < c_q.vin_off[10:0]) begin
         c_d.uv_ok = 1'b0;
      end
      c_d.read_vin  = {`EXP_M3, 1'b0, vin_corr[9:0]};
      c_d.read_vout = c_q.vout2 + VOUT_OFS_CAL;

      // Margin selection picks the target the power stage regulates to.
      unique case (c_q.op[`OP_MARGIN_MSB:`OP_MARGIN_LSB])
         `MARGIN_LOW:  c_d.vout_target = c_q.margin_lo;
         `MARGIN_HIGH: c_d.vout_target = c_q.margin_hi;
         default:      c_d.vout_target = c_q.vout_set;
      endcase

      // Timers count in half-millisecond steps from the tick divider.
      c_d.tick = (c_q.tick == 16'(TON_STEP_CYCLES - 1)) ? 16'h0000
                                                        : c_q.tick + 16'h1;
      unique case (c_q.pst)
         pmbus_cmd_pkg::PWR_OFF: begin
            c_d.cnt  = 11'h000;
            c_d.tick = 16'h0000;
            if (want) begin
               c_d.pst = pmbus_cmd_pkg::PWR_DELAY;
            end
         end
         pmbus_cmd_pkg::PWR_DELAY: begin
            if (c_q.tick == 16'(TON_STEP_CYCLES - 1)) begin
               c_d.cnt = c_q.cnt + 11'h1;
            end
            if (!want) begin
               c_d.pst = pmbus_cmd_pkg::PWR_OFF;
            end else if (c_q.cnt >= c_q.ton_delay[10:0]) begin
               c_d.pst = pmbus_cmd_pkg::PWR_RISE;
               c_d.cnt = 11'h000;
            end
         end
         pmbus_cmd_pkg::PWR_RISE: begin
            if (c_q.tick == 16'(TON_STEP_CYCLES - 1)) begin
               c_d.cnt = c_q.cnt + 11'h1;
            end
            if (!want) begin
               c_d.pst = pmbus_cmd_pkg::PWR_OFF;
            end else if (c_q.cnt >= c_q.ton_rise[10:0]) begin
               c_d.pst = pmbus_cmd_pkg::PWR_ON;
            end
         end
         pmbus_cmd_pkg::PWR_ON: begin
            if (!want) begin
               c_d.pst = pmbus_cmd_pkg::PWR_OFF;
            end
         end
         default: c_d.pst = pmbus_cmd_pkg::PWR_OFF;
      endcase
      c_d.pwr_en     = (c_d.pst == pmbus_cmd_pkg::PWR_RISE) ||
                       (c_d.pst == pmbus_cmd_pkg::PWR_ON);
      c_d.soft_start = (c_d.pst == pmbus_cmd_pkg::PWR_RISE);
   end

   // Core registers; protection comes up active on every reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         c_q           <= '0;
         c_q.op        <= `OP_RST;
         c_q.cfg_cmd   <= 1'(`CFG_RST >> `CFG_CMD_BIT);
         c_q.wp        <= `WP_RST;
         c_q.vin_on    <= `VIN_ON_RST;
         c_q.vin_off   <= `VIN_OFF_RST;
         c_q.ton_delay <= `TON_DELAY_RST;
         c_q.ton_rise  <= `TON_RISE_RST;
         c_q.vout_set  <= `VOUT_SET_RST;
         c_q.margin_hi <= `MARGIN_HI_RST;
         c_q.margin_lo <= `MARGIN_LO_RST;
         c_q.pst       <= pmbus_cmd_pkg::PWR_OFF;
         c_q.vout_target <= `VOUT_SET_RST;
      end else begin
         c_q <= c_d;
      end
   end

   // Non-volatile image: never reset, since it must outlive power loss.
   always_ff @(posedge clk) begin
      if (c_q.store) begin
         nvm[0] <= c_q.vin_on;
         nvm[1] <= c_q.vin_off;
         nvm[2] <= c_q.ton_delay;
         nvm[3] <= c_q.ton_rise;
         nvm[4] <= c_q.vout_set;
         nvm[5] <= c_q.margin_hi;
         nvm[6] <= c_q.margin_lo;
         nvm[7] <= {8'h00, c_q.op[7:5], c_q.cfg_cmd, 4'h0};
      end
   end

   assign link_rd_byte = l_q.rd_byte;
   assign link_busy    = l_q.busy;
   assign pwr_enable   = c_q.pwr_en;
   assign soft_start   = c_q.soft_start;
   assign vout_target  = c_q.vout_target;
   assign wp_active    = c_q.wp;
   assign cmd_refused  = c_q.refused;

   ////////////////////////////////////////////////////////////////////////
   // Checks on the core domain, plus one readback-order check on the link clock.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_WP_BLOCKS_SET: assert property (
      exec && c_q.wp && l_q.req_n == 2'h2 |=> $stable(c_q.vout_set)
   ) else $error("Protected word write changed the set-point.");
   AST_RANGE_REFUSE: assert property (
      exec && !c_q.wp && l_q.req_n == 2'h2 && l_q.req_cmd == `CMD_VIN_ON &&
      l_q.req_data[10:0] > `VIN_MANT_MAX |=> cmd_refused && $stable(c_q.vin_on)
   ) else $error("Out-of-range threshold was taken.");
   AST_OFF_WHEN_BIT7_LOW: assert property (
      c_q.cfg_cmd && !c_q.op[`OP_ON_BIT] |-> ##2 !pwr_enable
   ) else $error("Output enabled while operation bit 7 is clear.");
   AST_PIN_REQUIRED: assert property (
      !c_q.pin2 |-> ##2 !pwr_enable
   ) else $error("Output enabled with the on/off pin released.");
   AST_MARGIN_HIGH: assert property (
      c_q.op[5:2] == `MARGIN_HIGH |=> vout_target == $past(c_q.margin_hi)
   ) else $error("Margin high did not select the high level.");
   AST_DELAY_BEFORE_RISE: assert property (
      c_q.pst == pmbus_cmd_pkg::PWR_OFF ##1
      c_q.pst == pmbus_cmd_pkg::PWR_DELAY |-> !soft_start [*8]
   ) else $error("Rise began without the turn-on delay.");
   AST_STORE_PULSE: assert property (
      exec && l_q.req_n == 2'h0 && l_q.req_cmd == `CMD_STORE_ALL
      |=> c_q.store ##1 !c_q.store
   ) else $error("Store-all did not commit exactly once.");
   AST_WP_RESET: assert property (
      $rose(arst_n) |-> wp_active
   ) else $error("Write protection not active after reset.");
   AST_READ_VIN_EXP: assert property (
      exec && l_q.req_n == 2'h0 && l_q.req_cmd == `CMD_READ_VIN |=>
      c_q.rd_word[15:10] == {`EXP_M3, 1'b0}
   ) else $error("Input readback exponent or sign field wrong.");
   AST_LINK_LOW_FIRST: assert property (
      @(posedge link_clk) disable iff (!arst_n)
      link_rd_valid && !l_q.rd_hi && !(l_q.ack3 != l_q.ack2) |=>
      link_rd_byte == $past(l_q.rd_word[7:0])
   ) else $error("Readback did not start with the low byte.");

   COV_POWER_ON: cover property (c_q.pst == pmbus_cmd_pkg::PWR_ON);
   COV_REFUSED:  cover property (cmd_refused && c_q.wp);
   COV_MARGIN:   cover property (c_q.op[5:2] == `MARGIN_LOW && pwr_enable);

endmodule : pmbus_power_command_set

/* File: bench/link_host.sv */
// Host model on the byte link: frames writes and pulls readback bytes.
// Assumes the block answers with busy and holds rd_byte until next ask.
`timescale 1ns/1ps
module link_host (
   output logic       link_clk,
   output logic       wr_valid,
   output logic [7:0] wr_byte,
   output logic       wr_last,
   output logic       rd_valid,
   input  wire logic  busy,
   input  wire logic [7:0] rd_byte
);
   logic run = 1'b0;

   // The link clock stands still outside frames, as a real host's would.
   initial {link_clk, wr_valid, wr_byte, wr_last, rd_valid} = '0;
   always begin
      #16;
      link_clk = run ? ~link_clk : 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Code byte, then data low byte before high byte; waits for busy low.
   task automatic send(input logic [7:0] c, input logic [15:0] d,
                       input int n);
      run = 1'b1;
      for (int i = 0; i <= n; i++) begin
         @(posedge link_clk);
         wr_valid <= 1'b1;
         wr_byte  <= (i == 0) ? c : (i == 1) ? d[7:0] : d[15:8];
         wr_last  <= (i == n);
      end
      @(posedge link_clk);
      wr_valid <= 1'b0;
      wr_last  <= 1'b0;
      wr_byte  <= ~wr_byte;
      repeat (2) @(posedge link_clk);
      while (busy) @(posedge link_clk);
      run = 1'b0;
   endtask : send

   // Selects a word and fetches it low byte first.
   task automatic read(input logic [7:0] c, output logic [15:0] w);
      send(c, 16'h0000, 0);
      run = 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(posedge link_clk);
         rd_valid <= 1'b1;
         @(posedge link_clk);
         rd_valid <= 1'b0;
         @(posedge link_clk);
         w[8*i +: 8] = rd_byte;
      end
      run = 1'b0;
   endtask : read
endmodule : link_host

/* File: bench/pmbus_power_command_set_tb.sv */
// Self-checking bench for the converter command set.
// Assumes the link host model and a shortened start-up step of 4 cycles.
`timescale 1ns/1ps
`include "pmbus_cmd_defs.svh"
module pmbus_power_command_set_tb;
   logic        clk, arst_n, lclk, wv, wl, rv, busy, pin, pe, ss, wp, rf;
   logic [7:0]  wb, rb;
   logic [15:0] vin, vout, vt, w, m;
   int          fail_count = 0, total_checks = 0, cyc = 0, nref = 0;

   pmbus_power_command_set #(.TON_STEP_CYCLES(4), .VOUT_OFS_CAL(16'h0010))
      pmbus_power_command_set_i (
      .clk(clk), .arst_n(arst_n), .link_clk(lclk), .link_wr_valid(wv),
      .link_wr_byte(wb), .link_wr_last(wl), .link_rd_valid(rv),
      .link_rd_byte(rb), .link_busy(busy), .onoff_pin(pin), .adc_vin(vin),
      .adc_vout(vout), .pwr_enable(pe), .soft_start(ss), .vout_target(vt),
      .wp_active(wp), .cmd_refused(rf));
   link_host link_host_i (.link_clk(lclk), .wr_valid(wv), .wr_byte(wb),
      .wr_last(wl), .rd_valid(rv), .busy(busy), .rd_byte(rb));

   ////////////////////////////////////////////////////////////////////
   // Clock, refusal pulse counter and hang guard.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      cyc++;
      if (rf === 1'b1) nref++;
      if (cyc > 20000) begin
         fail_count++;
         complete_run();
      end
   end

   task automatic check(input string nm, input logic [15:0] e, a);
      total_checks++;
      if (a !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, a);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run

   // A write, then whether the block turned it down.
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n,
                     input int r);
      int r0;
      r0 = nref;
      link_host_i.send(c, d, n);
      repeat (3) @(negedge clk);
      check("refused", 16'(r), 16'(nref - r0));
   endtask : wr

   // Corrected input reading with unit gain and zero offset mantissa.
   function automatic logic [15:0] vin_word(input logic [15:0] a);
      return {`EXP_M3, a[10:0]};
   endfunction : vin_word

   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h852F8865));
      {arst_n, pin} = 2'b10;
      #1;
      arst_n = 1'b0;
      vin  = 16'h0140;
      vout = 16'hB000;
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      check("wp", 16'h0001, 16'(wp));
      check("target", 16'hC000, vt);
      wr(`CMD_VOUT_SET, 16'hA000, 2, 1);
      wr(`CMD_WP_CTRL, 16'h0000, 1, 0);
      check("wp", 16'h0000, 16'(wp));
      wr(`CMD_VOUT_SET, 16'hA000, 2, 0);
      wr(`CMD_VOUT_SET, 16'h9000, 2, 1);
      link_host_i.read(`CMD_VOUT_SET, w);
      check("setpoint", 16'hA000, w);
      wr(`CMD_VIN_ON, 16'hE971, 2, 1);
      wr(`CMD_VIN_ON, 16'hF130, 2, 1);
      wr(`CMD_VIN_ON, 16'hE930, 2, 0);
      wr(`CMD_VIN_OFF, 16'hE920, 2, 0);
      wr(`CMD_TON_DELAY, 16'hF813, 2, 1);
      wr(`CMD_TON_RISE, 16'hFBE9, 2, 1);
      wr(`CMD_STORE_ALL, 16'h0000, 0, 0);
      m = 16'h9800 + 16'($urandom_range(0, 16'h2800));
      wr(`CMD_MARGIN_HI, m, 2, 0);
      wr(`CMD_OPERATION, 16'h0028, 1, 0);
      check("margin high", m, vt);
      wr(`CMD_OPERATION, 16'h0018, 1, 0);
      check("margin low", 16'h9800, vt);
      wr(`CMD_OPERATION, 16'h000C, 1, 0);
      check("margin off", 16'hA000, vt);
      wr(`CMD_ONOFF_CFG, 16'h0000, 1, 0);
      link_host_i.read(`CMD_ONOFF_CFG, w);
      check("config", 16'h0017, {8'h00, w[7:0]});
      wr(`CMD_ONOFF_CFG, 16'h0008, 1, 0);
      vout = 16'(16'h9800 + $urandom_range(0, 16'h2800));
      repeat (4) @(negedge clk);
      link_host_i.read(`CMD_READ_VOUT, w);
      check("vout read", vout + 16'h0010, w);
      link_host_i.read(`CMD_VOUT_MODE, w);
      check("vout mode", 16'h0014, w);
      link_host_i.read(`CMD_READ_VIN, w);
      check("vin read", vin_word(vin), w);
      link_host_i.read(`CMD_VOUT_OFS_CAL, w);
      check("vout ofs", 16'h0010, w);
      link_host_i.read(`CMD_VIN_OFS_CAL, w);
      check("vin ofs", 16'hE800, w);
      link_host_i.read(`CMD_VIN_GAIN_CAL, w);
      check("vin gain", 16'h2000, w);
      // Start-up: pin low must hold the output off, then delay and rise.
      wr(`CMD_OPERATION, 16'h0080, 1, 0);
      repeat (300) @(negedge clk);
      check("pin gate", 16'h0000, 16'(pe));
      pin = 1'b1;
      repeat (60) @(negedge clk);
      check("delay", 16'h0000, 16'(pe));
      for (int i = 0; i < 100 && ss !== 1'b1; i++) @(negedge clk);
      check("rise", 16'h0003, {14'h0, pe, ss});
      for (int i = 0; i < 200 && ss !== 1'b0; i++) @(negedge clk);
      check("on", 16'h0002, {14'h0, pe, ss});
      wr(`CMD_OPERATION, 16'h0000, 1, 0);
      check("off", 16'h0000, 16'(pe));
      wr(`CMD_WP_CTRL, 16'h0001, 1, 0);
      check("wp", 16'h0001, 16'(wp));
      wr(`CMD_ONOFF_CFG, 16'h0000, 1, 1);
      complete_run();
   end
endmodule : pmbus_power_command_set_tb
